// file: src/fps_pkg.sv
// ==========================================================================
// shared constants and carriers
package fps_pkg;

  // ========================================================================
  // clocking
  localparam int CLK_HZ        = 10_000_000;
  localparam int MCLK_FAST_HZ  = 360_000;
  localparam int MCLK_SLOW_HZ  = 1_400;
  // nearest whole divide of the system clock
  localparam int MCLK_FAST_DIV = (CLK_HZ + MCLK_FAST_HZ / 2) / MCLK_FAST_HZ;
  localparam int MCLK_SLOW_DIV = (CLK_HZ + MCLK_SLOW_HZ / 2) / MCLK_SLOW_HZ;

  // ========================================================================
  // spin-up timing: shortest kick, longer codes double it
  localparam int KICK_BASE_MS  = 50;
  localparam int KICK_BASE_CYC = (CLK_HZ / 1000) * KICK_BASE_MS;
  localparam int KICK_CNT_W    = 32;

  // ========================================================================
  // register offsets
  localparam logic [7:0] OFS_DRIVE_CFG = 8'h4a;
  localparam logic [7:0] OFS_KICK_CFG  = 8'h4b;
  localparam logic [7:0] OFS_DUTY      = 8'h4c;
  localparam logic [7:0] OFS_FREQ      = 8'h4d;

  // ========================================================================
  // reset values
  localparam logic [7:0] DRIVE_CFG_RST = 8'h20;
  localparam logic [7:0] KICK_CFG_RST  = 8'h3f;
  localparam logic [4:0] FREQ_RST      = 5'h00;
  localparam logic [5:0] DUTY_RST      = 6'h00;

  // ========================================================================
  // duty scale: 64 steps per period
  localparam int         DUTY_W        = 6;
  localparam int         FREQ_W        = 5;
  localparam logic [5:0] DUTY_ZERO     = 6'h00;
  localparam logic [5:0] KICK_DUTY_50  = 6'h20;
  localparam logic [5:0] KICK_DUTY_75  = 6'h30;

  // ========================================================================
  // field codes
  localparam logic [1:0] TACH_MODE_STD = 2'h0;
  localparam logic [1:0] KDUTY_NONE    = 2'h0;
  localparam logic [1:0] KDUTY_50      = 2'h1;
  localparam logic [1:0] KDUTY_75      = 2'h2;
  localparam logic [1:0] KDUTY_FULL    = 2'h3;
  localparam logic [2:0] KDUR_NONE     = 3'h0;

  // ========================================================================
  // register layouts
  typedef struct packed {
    logic [1:0] unused;
    logic       manual;
    logic       polarity;
    logic       clk_slow;
    logic       rsvd;
    logic [1:0] tach_mode;
  } fps_drive_cfg_type;

  typedef struct packed {
    logic [1:0] unused;
    logic       early_exit;
    logic [1:0] duty;
    logic [2:0] dur;
  } fps_kick_cfg_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fps_bus_req_type;

  typedef enum logic [0:0] {
    KS_IDLE = 1'b0,
    KS_RUN  = 1'b1
  } fps_kick_state_type;

endpackage

// file: src/fps_kick_timer.sv
`timescale 1ns/1ps
// ==========================================================================
// spin-up duration timer
module fps_kick_timer #(
  parameter int BASE_CYC = fps_pkg::KICK_BASE_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       ce_i,
  input  wire logic       start_i,
  input  wire logic       abort_i,
  input  wire logic [2:0] dur_i,
  output logic            active_o
);

  fps_pkg::fps_kick_state_type state_r;
  fps_pkg::fps_kick_state_type state_nxt;
  logic [fps_pkg::KICK_CNT_W-1:0] cnt_r;
  logic [fps_pkg::KICK_CNT_W-1:0] cnt_nxt;
  logic [fps_pkg::KICK_CNT_W-1:0] limit;
  logic [2:0]                     shift;
  logic                           expired;

  // code 1 is the base, each further code doubles it
  assign shift   = dur_i - 3'h1;
  assign limit   = fps_pkg::KICK_CNT_W'(BASE_CYC) << shift;
  assign expired = (cnt_r >= limit - 1'b1);

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      fps_pkg::KS_IDLE:
      begin
        cnt_nxt = '0;
        if (start_i)
          state_nxt = fps_pkg::KS_RUN;
      end
      fps_pkg::KS_RUN:
      begin
        cnt_nxt = cnt_r + 1'b1;
        // whichever comes first ends the kick
        if (expired || abort_i || dur_i == fps_pkg::KDUR_NONE)
        begin
          state_nxt = fps_pkg::KS_IDLE;
          cnt_nxt   = '0;
        end
      end
      default:
      begin
        state_nxt = fps_pkg::KS_IDLE;
        cnt_nxt   = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      state_r <= fps_pkg::KS_IDLE;
      cnt_r   <= '0;
    end
    else if (ce_i)
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign active_o = (state_r == fps_pkg::KS_RUN);

endmodule // fps_kick_timer

// file: src/fps_pwm_gen.sv
`timescale 1ns/1ps
// ==========================================================================
// master clock prescaler and duty comparator
module fps_pwm_gen #(
  parameter int FAST_DIV = fps_pkg::MCLK_FAST_DIV,
  parameter int SLOW_DIV = fps_pkg::MCLK_SLOW_DIV
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_b_i,
  input  wire logic                      ce_i,
  input  wire logic                      clk_slow_i,
  input  wire logic [fps_pkg::FREQ_W-1:0] freq_div_i,
  input  wire logic [fps_pkg::DUTY_W-1:0] duty_i,
  input  wire logic                      full_i,
  output logic                           fan_on_o
);

  logic [15:0]                 pre_r;
  logic [15:0]                 pre_limit;
  logic [fps_pkg::FREQ_W-1:0]  div_r;
  logic [fps_pkg::DUTY_W-1:0]  step_r;
  logic                        mtick;
  logic                        step_tick;
  logic                        on_nxt;

  assign pre_limit = clk_slow_i ? 16'(SLOW_DIV - 1)
                                : 16'(FAST_DIV - 1);
  assign mtick     = (pre_r >= pre_limit);
  assign step_tick = mtick && (div_r >= freq_div_i);
  assign on_nxt    = full_i || (step_r < duty_i);

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      pre_r    <= '0;
      div_r    <= '0;
      step_r   <= '0;
      fan_on_o <= 1'b0;
    end
    else if (ce_i)
    begin
      pre_r    <= mtick ? 16'h0000 : pre_r + 16'h0001;
      if (mtick)
        div_r  <= step_tick ? '0 : div_r + 1'b1;
      if (step_tick)
        step_r <= step_r + 1'b1;
      fan_on_o <= on_nxt;
    end
  end

endmodule // fps_pwm_gen

// file: src/fps_fan_drive.sv
`timescale 1ns/1ps
module fps_fan_drive #(
  parameter int KICK_BASE_CYC = fps_pkg::KICK_BASE_CYC,
  parameter int SLOW_DIV      = fps_pkg::MCLK_SLOW_DIV
) (
  input  wire logic       SYS_CLK_I,
  input  wire logic       RST_B_I,
  input  wire logic       CE_I,
  input  wire logic [7:0] REG_ADDR_I,
  input  wire logic [7:0] REG_WDATA_I,
  input  wire logic       REG_WR_I,
  input  wire logic       REG_RD_I,
  output logic      [7:0] REG_RDATA_O,
  input  wire logic [5:0] LUT_DUTY_I,
  input  wire logic       TACH_MIN_REACHED_I,
  output logic            LUT_WR_EN_O,
  output logic      [1:0] TACH_MODE_O,
  output logic            KICK_ACTIVE_O,
  output logic            FAN_PWM_O,
  output logic            FAN_PWM_OE_O
);

  // ========================================================================
  // kick duty decode
  function automatic logic [5:0] kick_duty_f(input logic [1:0] code);
    case (code)
      fps_pkg::KDUTY_50: kick_duty_f = fps_pkg::KICK_DUTY_50;
      fps_pkg::KDUTY_75: kick_duty_f = fps_pkg::KICK_DUTY_75;
      default:           kick_duty_f = fps_pkg::DUTY_ZERO;
    endcase
  endfunction

  // ========================================================================
  // bus request and register state
  fps_pkg::fps_bus_req_type   req;
  fps_pkg::fps_drive_cfg_type cfg_r;
  fps_pkg::fps_drive_cfg_type cfg_nxt;
  fps_pkg::fps_kick_cfg_type  kick_r;
  fps_pkg::fps_kick_cfg_type  kick_nxt;
  logic [4:0]                 freq_r;
  logic [5:0]                 duty_man_r;
  logic [7:0]                 rdata_r;
  logic [7:0]                 rdata_nxt;
  logic                       prev_zero_r;
  logic [1:0]                 tach_mode_r;
  logic                       pin_oe_r;

  assign req.wr    = REG_WR_I;
  assign req.rd    = REG_RD_I;
  assign req.addr  = REG_ADDR_I;
  assign req.wdata = REG_WDATA_I;

  // ========================================================================
  // address decode
  wire hit_cfg  = (req.addr == fps_pkg::OFS_DRIVE_CFG);
  wire hit_kick = (req.addr == fps_pkg::OFS_KICK_CFG);
  wire hit_duty = (req.addr == fps_pkg::OFS_DUTY);
  wire hit_freq = (req.addr == fps_pkg::OFS_FREQ);

  wire wr_cfg   = req.wr && hit_cfg;
  wire wr_kick  = req.wr && hit_kick;
  wire wr_freq  = req.wr && hit_freq;
  // duty register only accepts writes in manual mode
  wire wr_duty  = req.wr && hit_duty && cfg_r.manual;

  // upper bits are never stored, so they cannot read back nonzero
  always_comb
  begin
    cfg_nxt          = cfg_r;
    kick_nxt         = kick_r;
    if (wr_cfg)
      cfg_nxt        = fps_pkg::fps_drive_cfg_type'(req.wdata);
    if (wr_kick)
      kick_nxt       = fps_pkg::fps_kick_cfg_type'(req.wdata);
    cfg_nxt.unused   = 2'h0;
    kick_nxt.unused  = 2'h0;
  end

  // ========================================================================
  // duty source and kick control
  logic [5:0] cmd_duty;
  logic       cmd_zero;
  logic       kick_bypass;
  logic       kick_start;
  logic       kick_abort;
  logic       kick_full;
  logic       kick_active;
  logic [5:0] out_duty;
  logic       out_full;
  logic       fan_on;

  assign cmd_duty    = cfg_r.manual ? duty_man_r
                                    : LUT_DUTY_I;
  assign cmd_zero    = (cmd_duty == fps_pkg::DUTY_ZERO);
  // no duration means no kick at all; no duty needs early exit to kick
  assign kick_bypass = (kick_r.dur == fps_pkg::KDUR_NONE) ||
                       ((kick_r.duty == fps_pkg::KDUTY_NONE) &&
                        !kick_r.early_exit);
  assign kick_start  = prev_zero_r && !cmd_zero && !kick_bypass;
  assign kick_abort  = kick_r.early_exit && TACH_MIN_REACHED_I;
  assign kick_full   = kick_r.early_exit ||
                       (kick_r.duty == fps_pkg::KDUTY_FULL);
  assign out_duty    = kick_active ? kick_duty_f(kick_r.duty)
                                   : cmd_duty;
  assign out_full    = kick_active && kick_full;

  fps_kick_timer #(
    .BASE_CYC (KICK_BASE_CYC)
  ) u_kick (
    .clk_i    (SYS_CLK_I),
    .rst_b_i  (RST_B_I),
    .ce_i     (CE_I),
    .start_i  (kick_start),
    .abort_i  (kick_abort),
    .dur_i    (kick_r.dur),
    .active_o (kick_active)
  );

  fps_pwm_gen #(
    .FAST_DIV   (fps_pkg::MCLK_FAST_DIV),
    .SLOW_DIV   (SLOW_DIV)
  ) u_pwm (
    .clk_i      (SYS_CLK_I),
    .rst_b_i    (RST_B_I),
    .ce_i       (CE_I),
    .clk_slow_i (cfg_r.clk_slow),
    .freq_div_i (freq_r),
    .duty_i     (out_duty),
    .full_i     (out_full),
    .fan_on_o   (fan_on)
  );

  // ========================================================================
  // read mux
  wire [7:0] rd_cfg  = {2'h0, cfg_r[5:0]};
  wire [7:0] rd_kick = {2'h0, kick_r[5:0]};
  wire [7:0] rd_freq = {3'h0, freq_r};
  // duty hides during a kick so software never mistakes it for the command
  wire [7:0] rd_duty = kick_active ? 8'h00 : {2'h0, cmd_duty};

  always_comb
  begin
    rdata_nxt = 8'h00;
    if (req.rd)
    begin
      if (hit_cfg)
        rdata_nxt = rd_cfg;
      else if (hit_kick)
        rdata_nxt = rd_kick;
      else if (hit_duty)
        rdata_nxt = rd_duty;
      else if (hit_freq)
        rdata_nxt = rd_freq;
      else
        rdata_nxt = 8'h00;
    end
  end

  // ========================================================================
  // derived pin and mode state
  // the mode field is kept as written; only its use is forced
  wire [1:0] tach_mode_nxt = cfg_r.clk_slow ? cfg_r.tach_mode
                                            : fps_pkg::TACH_MODE_STD;
  // open-drain: pull low for off when clear, for on when set
  wire       pin_oe_nxt    = ~(fan_on ^ cfg_r.polarity);

  // ========================================================================
  // registers
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_B_I)
    begin
      cfg_r       <= fps_pkg::fps_drive_cfg_type'(fps_pkg::DRIVE_CFG_RST);
      kick_r      <= fps_pkg::fps_kick_cfg_type'(fps_pkg::KICK_CFG_RST);
      freq_r      <= fps_pkg::FREQ_RST;
      duty_man_r  <= fps_pkg::DUTY_RST;
      rdata_r     <= 8'h00;
      prev_zero_r <= 1'b1;
      tach_mode_r <= fps_pkg::TACH_MODE_STD;
      pin_oe_r    <= 1'b1;
    end
    else if (CE_I)
    begin
      cfg_r       <= cfg_nxt;
      kick_r      <= kick_nxt;
      if (wr_freq)
        freq_r    <= req.wdata[4:0];
      if (wr_duty)
        duty_man_r <= req.wdata[5:0];
      rdata_r     <= rdata_nxt;
      prev_zero_r <= cmd_zero;
      tach_mode_r <= tach_mode_nxt;
      pin_oe_r    <= pin_oe_nxt;
    end
  end

  // ========================================================================
  // outputs
  assign REG_RDATA_O   = rdata_r;
  assign LUT_WR_EN_O   = cfg_r.manual;
  assign TACH_MODE_O   = tach_mode_r;
  assign KICK_ACTIVE_O = kick_active;
  assign FAN_PWM_O     = 1'b0;
  assign FAN_PWM_OE_O  = pin_oe_r;

endmodule // fps_fan_drive

// file: sim/fps_fan_drive_checker.sv
`timescale 1ns/1ps
// ====
// port-level checks of the fan drive
module fps_fan_drive_checker #(
  parameter int KICK_BASE_CYC = fps_pkg::KICK_BASE_CYC,
  parameter int SLOW_DIV      = fps_pkg::MCLK_SLOW_DIV
) (
  input wire logic       SYS_CLK_I,
  input wire logic       RST_B_I,
  input wire logic       CE_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic       REG_WR_I,
  input wire logic       REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic [5:0] LUT_DUTY_I,
  input wire logic       TACH_MIN_REACHED_I,
  input wire logic       LUT_WR_EN_O,
  input wire logic [1:0] TACH_MODE_O,
  input wire logic       KICK_ACTIVE_O,
  input wire logic       FAN_PWM_O,
  input wire logic       FAN_PWM_OE_O
);
  logic       pol_r;
  logic       man_r;
  logic       dz_r;
  logic [1:0] mode_r;
  logic [5:0] kick_r;
  int         kick_len_r;
  wire wr_a = REG_WR_I && CE_I && REG_ADDR_I == 8'h4a;
  wire wr_b = REG_WR_I && CE_I && REG_ADDR_I == 8'h4b;
  wire wr_c = REG_WR_I && CE_I && REG_ADDR_I == 8'h4c && man_r;
  wire rd_c = REG_RD_I && CE_I && REG_ADDR_I == 8'h4c;
  wire rd_d = REG_RD_I && CE_I && REG_ADDR_I == 8'h4d;
  wire rd_ab = REG_RD_I && CE_I && REG_ADDR_I[7:1] == 7'h25;
  wire full = kick_r[5] || kick_r[4:3] == 2'h3;

  // ====
  // shadow of the settings the checks depend on
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_B_I)
    begin
      pol_r  <= 1'b0;
      man_r  <= 1'b1;
      dz_r   <= 1'b1;
      mode_r <= 2'h0;
      kick_r <= 6'h3f;
      kick_len_r <= 0;
    end
    else
    begin
      if (wr_a)
      begin
        pol_r  <= REG_WDATA_I[4];
        man_r  <= REG_WDATA_I[5];
        mode_r <= REG_WDATA_I[3] ? REG_WDATA_I[1:0] : 2'h0;
      end
      if (wr_b)
        kick_r <= REG_WDATA_I[5:0];
      if (wr_c)
        dz_r <= REG_WDATA_I[5:0] == 6'h00;
      // length of the running kick in enabled cycles
      if (CE_I)
        kick_len_r <= KICK_ACTIVE_O ? kick_len_r + 1 : 0;
    end
  end

  // ====
  // assertions
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_B_I);

  a_unused_zero: assert property (
    rd_ab |=> REG_RDATA_O[7:6] == 2'h0)
    else $error("upper config bits read nonzero");
  a_freq_unused: assert property (
    rd_d |=> REG_RDATA_O[7:5] == 3'h0)
    else $error("upper frequency bits read nonzero");
  a_kick_reads_zero: assert property (
    rd_c && KICK_ACTIVE_O |=> REG_RDATA_O == 8'h00)
    else $error("duty read nonzero during kick");
  a_lut_enable: assert property (
    LUT_WR_EN_O == man_r)
    else $error("table write enable differs from manual bit");
  a_fast_mode: assert property (
    wr_a ##1 (CE_I && !wr_a) |=> TACH_MODE_O == mode_r)
    else $error("speed-sense mode wrong for clock choice");
  a_kick_bypass: assert property (
    $rose(KICK_ACTIVE_O) |->
      kick_r[2:0] != 3'h0 && (kick_r[5] || kick_r[4:3] != 2'h0))
    else $error("kick started while bypassed");
  a_kick_full: assert property (
    (KICK_ACTIVE_O && full)[*3] |-> FAN_PWM_OE_O == pol_r)
    else $error("kick output not at full duty");
  a_early_stop: assert property (
    KICK_ACTIVE_O && kick_r[5] && TACH_MIN_REACHED_I |->
      ##[1:3] !KICK_ACTIVE_O)
    else $error("kick kept running past tach setpoint");
  a_fan_off: assert property (
    (man_r && dz_r && !KICK_ACTIVE_O && !wr_a)[*4] |->
      FAN_PWM_OE_O == !pol_r)
    else $error("fan-off level wrong for polarity");
  a_drain_only: assert property (
    FAN_PWM_O == 1'b0)
    else $error("output data not held low");
  a_kick_length: assert property (
    $fell(KICK_ACTIVE_O) && !kick_r[5] |->
      kick_len_r == (KICK_BASE_CYC << (kick_r[2:0] - 3'h1)))
    else $error("timed kick length differs from duration code");

  c_kick_read: cover property (rd_c && KICK_ACTIVE_O);
  c_early_end: cover property (
    KICK_ACTIVE_O && kick_r[5] && TACH_MIN_REACHED_I);
  c_timed_end: cover property ($fell(KICK_ACTIVE_O) && !kick_r[5]);
endmodule // fps_fan_drive_checker

bind fps_fan_drive fps_fan_drive_checker #(
  .KICK_BASE_CYC(KICK_BASE_CYC), .SLOW_DIV(SLOW_DIV)
) fps_fan_drive_checker_inst (
  .SYS_CLK_I(SYS_CLK_I), .RST_B_I(RST_B_I), .CE_I(CE_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
  .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
  .LUT_DUTY_I(LUT_DUTY_I), .TACH_MIN_REACHED_I(TACH_MIN_REACHED_I),
  .LUT_WR_EN_O(LUT_WR_EN_O), .TACH_MODE_O(TACH_MODE_O),
  .KICK_ACTIVE_O(KICK_ACTIVE_O), .FAN_PWM_O(FAN_PWM_O),
  .FAN_PWM_OE_O(FAN_PWM_OE_O)
);

// file: sim/fps_fan_model.sv
`timescale 1ns/1ps
// ====
// fan on a pulled-up open-drain line; speed builds while powered
module fps_fan_model #(
  parameter int SPIN = 300
) (
  input  wire logic clk_i,
  input  wire logic oe_i,
  output logic      pin_o,
  output logic      tach_o
);
  int spd = 0;
  // released line floats up to the pull-up level
  assign pin_o  = oe_i ? 1'b0 : 1'b1;
  assign tach_o = spd >= SPIN;
  always_ff @(posedge clk_i)
  begin
    if (pin_o && spd < SPIN)
      spd <= spd + 1;
    else if (!pin_o && spd > 0)
      spd <= spd - 1;
  end
endmodule // fps_fan_model

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic       clk;
  logic       rst_b = 1'b0;
  logic [7:0] addr  = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr    = 1'b0;
  logic       rd    = 1'b0;
  logic [5:0] lut   = 6'h00;
  logic       ce    = 1'b1;
  logic [7:0] rdata;
  logic       tach;
  logic       lut_en;
  logic [1:0] mode;
  logic       kick;
  logic       oe;
  logic       pin_dat;
  int         err_total = 0;
  int         samples_checked = 0;
  int         n;

  // short kick base and slow divide keep the run brief
  fps_fan_drive #(.KICK_BASE_CYC(20), .SLOW_DIV(8)) fps_fan_drive_inst (
    .SYS_CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_RDATA_O(rdata), .LUT_DUTY_I(lut),
    .TACH_MIN_REACHED_I(tach), .LUT_WR_EN_O(lut_en),
    .TACH_MODE_O(mode), .KICK_ACTIVE_O(kick), .FAN_PWM_O(pin_dat),
    .FAN_PWM_OE_O(oe)
  );
  fps_fan_model fps_fan_model_inst (
    .clk_i(clk), .oe_i(oe), .pin_o(), .tach_o(tach)
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ====
  // checks and bus access
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk_reg(rdata, e);
  endtask
  // counts cycles the fan is on over a window
  task automatic measure(input int win, input logic pol, output int on);
    on = 0;
    // skip the two-stage output pipeline so one duty fills the window
    repeat (2) @(negedge clk);
    repeat (win)
    begin
      @(negedge clk);
      if (oe === pol)
        on++;
    end
  endtask
  task automatic count_kick(output int k);
    k = 0;
    repeat (1300)
    begin
      @(negedge clk);
      if (kick === 1'b1)
        k++;
    end
  endtask
  // length of one whole pulse at the given output-enable level
  task automatic pulse_len(input logic lvl, output int len);
    len = 0;
    for (int i = 0; i < 4000 && oe !== lvl; i++)
      @(negedge clk);
    for (int i = 0; i < 4000 && oe === lvl; i++)
      @(negedge clk);
    for (int i = 0; i < 4000 && oe !== lvl; i++)
      @(negedge clk);
    for (int i = 0; i < 4000 && oe === lvl; i++)
    begin
      @(negedge clk);
      len++;
    end
  endtask
  task automatic final_report;
    $display("checked %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge clk);
    err_total++;
    final_report();
  end

  // ====
  // test sequence
  initial
  begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk(8'h4a, 8'h20);
    rd_chk(8'h4b, 8'h3f);
    rd_chk(8'h4d, 8'h00);
    rd_chk(8'h4e, 8'h00);
    wr_reg(8'h4a, 8'hfb);
    rd_chk(8'h4a, 8'h3b);
    wr_reg(8'h4b, 8'hff);
    rd_chk(8'h4b, 8'h3f);
    wr_reg(8'h4d, 8'hff);
    rd_chk(8'h4d, 8'h1f);
    // a write while the clock enable is low must be lost
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(8'h4d, 8'h05);
    ce <= 1'b1;
    rd_chk(8'h4d, 8'h1f);
    chk_reg({7'h00, pin_dat}, 8'h00);
    for (int m = 0; m < 4; m++)
    begin
      wr_reg(8'h4a, {6'h0a, m[1:0]});
      repeat (2) @(negedge clk);
      chk_reg({6'h00, mode}, {6'h00, m[1:0]});
      wr_reg(8'h4a, {6'h08, m[1:0]});
      repeat (2) @(negedge clk);
      chk_reg({6'h00, mode}, 8'h00);
    end
    // programming order: config, kick, frequency, table, then auto
    wr_reg(8'h4a, 8'h28);
    wr_reg(8'h4b, 8'h00);
    wr_reg(8'h4d, 8'h00);
    lut <= 6'h0a;
    wr_reg(8'h4a, 8'h08);
    wr_reg(8'h4c, 8'h15);
    rd_chk(8'h4c, 8'h0a);
    chk_reg({7'h00, lut_en}, 8'h00);
    wr_reg(8'h4a, 8'h28);
    rd_chk(8'h4c, 8'h00);
    chk_reg({7'h00, lut_en}, 8'h01);
    for (int c = 1; c < 4; c++)
    begin
      wr_reg(8'h4c, 8'h00);
      wr_reg(8'h4b, {3'h0, c[1:0], 3'h7});
      wr_reg(8'h4c, 8'h08);
      rd_chk(8'h4c, 8'h00);
      chk_reg({7'h00, kick}, 8'h01);
      measure(512, 1'b0, n);
      chk_cnt(n, (c + 1) * 128);
      for (int i = 0; i < 2000 && kick !== 1'b0; i++)
        @(negedge clk);
    end
    measure(512, 1'b0, n);
    chk_cnt(n, 64);
    for (int d = 0; d < 8; d++)
    begin
      wr_reg(8'h4c, 8'h00);
      wr_reg(8'h4b, {5'h03, d[2:0]});
      wr_reg(8'h4c, 8'h08);
      count_kick(n);
      chk_cnt(n, d == 0 ? 0 : 20 << (d - 1));
    end
    wr_reg(8'h4c, 8'h00);
    wr_reg(8'h4b, 8'h07);
    wr_reg(8'h4c, 8'h08);
    count_kick(n);
    chk_cnt(n, 0);
    // let the fan run down so the tach setpoint is not already met
    wr_reg(8'h4c, 8'h00);
    repeat (400) @(posedge clk);
    wr_reg(8'h4b, 8'h27);
    wr_reg(8'h4c, 8'h08);
    count_kick(n);
    chk_cnt(n > 299 && n < 311, 1);
    wr_reg(8'h4b, 8'h00);
    wr_reg(8'h4a, 8'h38);
    wr_reg(8'h4c, 8'h20);
    repeat (4) @(posedge clk);
    measure(512, 1'b1, n);
    chk_cnt(n, 256);
    pulse_len(1'b1, n);
    chk_cnt(n, 32 * 8);
    wr_reg(8'h4a, 8'h30);
    repeat (4) @(posedge clk);
    measure(64 * fps_pkg::MCLK_FAST_DIV, 1'b1, n);
    chk_cnt(n, 32 * fps_pkg::MCLK_FAST_DIV);
    pulse_len(1'b1, n);
    chk_cnt(n, 32 * fps_pkg::MCLK_FAST_DIV);
    wr_reg(8'h4c, 8'h00);
    repeat (4) @(posedge clk);
    measure(512, 1'b1, n);
    chk_cnt(n, 0);
    final_report();
  end
endmodule // tb_top
